// ### common/ims_defs.vh
// Constants for the two-wire memory slave front end.
// Assumes a single system clock that samples both serial lines.
//
// How it works
// - SDA rising while SCL high is stop; abort whatever is running.
// - SDA falling while SCL high is start; abort, await slave address.
// - SDA stays stable while SCL high except start/stop; sample high.
// - After eighth bit transmitter releases SDA; receiver pulls low to acknowledge.
// - Missing acknowledge stops the operation; device becomes addressable again.
// - First byte after start is taken as the slave address byte.
// - Upper four address bits must equal the memory type code.
// - Address bits three to one must match the device select pins.
// - Address bit zero selects direction: one read, zero write.
// - Master code 00001xxx enters high speed mode; stop leaves it.
// - Write sends two memory address bytes loaded into 15-bit latch.
// - Reads start at latched address, kept until rewritten.
// - Address latch increments after each data byte, before acknowledge.
// - Address latch wraps from highest location to zero.
// - No limit on bytes in one sequential read or write.
// - Read: send byte, sample acknowledge; continue on ack, end on none.
// - Write: receive each eight-bit byte, then drive acknowledge; no acknowledge while the write buffer is full.
// - All bytes are shifted most significant bit first.
// - Master makes the serial clock; device never drives it.
// - Launch output after SCL falling edge, capture input on rising.
// - Write protect high: no acknowledge, no address advance for data.
// - Most significant memory address bit is ignored.
`ifndef IMS_DEFS_VH
`define IMS_DEFS_VH

// ****************************************
// Address byte fields
// ****************************************
`define IMS_DEV_TYPE     4'ha
`define IMS_HS_CODE      5'h01
`define IMS_TYPE_MSB     7
`define IMS_TYPE_LSB     4
`define IMS_SEL_MSB      3
`define IMS_SEL_LSB      1
`define IMS_RW_BIT       0

// ****************************************
// Address latch
// ****************************************
`define IMS_ADDR_RESET   15'h0000
`define IMS_ADDR_LAST    15'h7fff
`define IMS_BITS_BYTE    4'h8

`endif

// ### rtl/ims_top.v
// Two-wire serial slave front end for a byte-wide memory.
// Assumes SCL and SDA arrive asynchronously and the memory answers a read
// request with rd_valid well inside one serial clock period.
`timescale 1ns/1ns
`include "ims_defs.vh"

module ims_top #(
  parameter AW = 15
) (
  input  wire          clk_sys,
  input  wire          rstn,
  input  wire          scl_in,
  input  wire          sda_in,
  output reg           sda_out,
  output reg           sda_oe,
  input  wire [2:0]    device_select_pins,
  input  wire          write_protect,
  output reg           wr_valid,
  input  wire          wr_ready,
  output reg  [AW-1:0] wr_addr,
  output reg  [7:0]    wr_data,
  output reg           rd_req,
  output reg  [AW-1:0] rd_addr,
  input  wire [7:0]    rd_data,
  input  wire          rd_valid,
  output reg           hs_mode,
  output reg           selected
);

  // ****************************************
  // Reset release
  // ****************************************
  reg rst_q1;
  reg rst_n;

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  // ****************************************
  // Line synchronisers and filter
  // ****************************************
  // Glitch of one sample is swallowed; costs one cycle of latency
  // SCL is only ever sampled; the slave never drives the clock
  reg       scl_s1;
  reg       scl_s2;
  reg       scl_s3;
  reg       sda_s1;
  reg       sda_s2;
  reg       sda_s3;
  reg       scl_f;
  reg       sda_f;
  reg       scl_q;
  reg       sda_q;
  reg [2:0] sel_s1;
  reg [2:0] sel_s2;
  reg       wp_s1;
  reg       wp_s2;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
      scl_f  <= 1'b1;
      sda_f  <= 1'b1;
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
      sel_s1 <= 3'h0;
      sel_s2 <= 3'h0;
      wp_s1  <= 1'b0;
      wp_s2  <= 1'b0;
    end else begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
      if (scl_s2 == scl_s3) begin
        scl_f <= scl_s3;
      end
      if (sda_s2 == sda_s3) begin
        sda_f <= sda_s3;
      end
      scl_q  <= scl_f;
      sda_q  <= sda_f;
      sel_s1 <= device_select_pins;
      sel_s2 <= sel_s1;
      wp_s1  <= write_protect;
      wp_s2  <= wp_s1;
    end
  end

  // Edges lag the pins by four clocks; SDA answers land some 4.5 clocks
  // after the SCL fall, so the master's low phase must be longer
  wire scl_rise = scl_f & ~scl_q;
  wire scl_fall = ~scl_f & scl_q;
  wire cond_start = scl_f & scl_q & sda_q & ~sda_f;
  wire cond_stop  = scl_f & scl_q & ~sda_q & sda_f;

  // ****************************************
  // Byte engine
  // ****************************************
  localparam ST_IDLE = 3'h0;
  localparam ST_RX   = 3'h1;
  localparam ST_ACK  = 3'h2;
  localparam ST_TX   = 3'h3;
  localparam ST_MACK = 3'h4;

  localparam K_SLAVE = 2'h0;
  localparam K_AHI   = 2'h1;
  localparam K_ALO   = 2'h2;
  localparam K_DATA  = 2'h3;

  function [AW-1:0] addr_inc;
    input [AW-1:0] a;
    begin
      if (a == `IMS_ADDR_LAST) begin
        addr_inc = `IMS_ADDR_RESET;
      end else begin
        addr_inc = a + {{(AW-1){1'b0}}, 1'b1};
      end
    end
  endfunction

  reg [2:0]    state;
  reg [1:0]    kind;
  reg [3:0]    bit_cnt;
  reg [7:0]    shreg;
  reg [6:0]    addr_hi;
  reg          rw_read;
  reg          ack_seen;
  reg [7:0]    rd_buf;
  reg          push;
  reg [AW-1:0] push_addr;
  reg [7:0]    push_data;
  reg          hold_v;

  wire [7:0] rx_byte = shreg;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state     <= ST_IDLE;
      kind      <= K_SLAVE;
      bit_cnt   <= 4'h0;
      shreg     <= 8'h00;
      addr_hi   <= 7'h00;
      rw_read   <= 1'b0;
      ack_seen  <= 1'b0;
      rd_buf    <= 8'hff;
      rd_addr   <= `IMS_ADDR_RESET;
      rd_req    <= 1'b0;
      push      <= 1'b0;
      push_addr <= `IMS_ADDR_RESET;
      push_data <= 8'h00;
      sda_out   <= 1'b0;
      sda_oe    <= 1'b0;
      hs_mode   <= 1'b0;
      selected  <= 1'b0;
    end else begin
      rd_req <= 1'b0;
      push   <= 1'b0;
      if (rd_valid) begin
        rd_buf <= rd_data;
      end
      if (cond_stop) begin
        state    <= ST_IDLE;
        sda_oe   <= 1'b0;
        selected <= 1'b0;
        hs_mode  <= 1'b0;
      end else if (cond_start) begin
        state    <= ST_RX;
        kind     <= K_SLAVE;
        bit_cnt  <= 4'h0;
        sda_oe   <= 1'b0;
        selected <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            sda_oe <= 1'b0;
          end
          ST_RX: begin
            if (scl_rise && bit_cnt != `IMS_BITS_BYTE) begin
              shreg   <= {shreg[6:0], sda_f};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == `IMS_BITS_BYTE) begin
              bit_cnt <= 4'h0;
              case (kind)
                K_SLAVE: begin
                  if (rx_byte[7:3] == `IMS_HS_CODE) begin
                    hs_mode <= 1'b1;
                    state   <= ST_IDLE;
                  end else if (rx_byte[`IMS_TYPE_MSB:`IMS_TYPE_LSB] == `IMS_DEV_TYPE
                      && rx_byte[`IMS_SEL_MSB:`IMS_SEL_LSB] == sel_s2) begin
                    rw_read  <= rx_byte[`IMS_RW_BIT];
                    selected <= 1'b1;
                    sda_oe   <= 1'b1;
                    state    <= ST_ACK;
                    rd_req   <= rx_byte[`IMS_RW_BIT];
                  end else begin
                    state <= ST_IDLE;
                  end
                end
                K_AHI: begin
                  addr_hi <= rx_byte[6:0];
                  sda_oe  <= 1'b1;
                  state   <= ST_ACK;
                end
                K_ALO: begin
                  rd_addr <= {addr_hi, rx_byte};
                  sda_oe  <= 1'b1;
                  state   <= ST_ACK;
                end
                default: begin
                  if (wp_s2 || hold_v) begin
                    // Full buffer answers with no acknowledge instead of losing data
                    state    <= ST_IDLE;
                    selected <= 1'b0;
                  end else begin
                    push      <= 1'b1;
                    push_addr <= rd_addr;
                    push_data <= rx_byte;
                    rd_addr   <= addr_inc(rd_addr);
                    sda_oe    <= 1'b1;
                    state     <= ST_ACK;
                  end
                end
              endcase
            end
          end
          ST_ACK: begin
            if (scl_rise) begin
              bit_cnt <= `IMS_BITS_BYTE;
            end else if (scl_fall && bit_cnt == `IMS_BITS_BYTE) begin
              bit_cnt <= 4'h0;
              if (rw_read) begin
                shreg  <= {rd_buf[6:0], 1'b0};
                sda_oe <= ~rd_buf[7];
                state  <= ST_TX;
              end else begin
                sda_oe <= 1'b0;
                state  <= ST_RX;
                if (kind == K_SLAVE) begin
                  kind <= K_AHI;
                end else if (kind == K_AHI) begin
                  kind <= K_ALO;
                end else begin
                  kind <= K_DATA;
                end
              end
            end
          end
          ST_TX: begin
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt == `IMS_BITS_BYTE) begin
                sda_oe  <= 1'b0;
                rd_addr <= addr_inc(rd_addr);
                rd_req  <= 1'b1;
                bit_cnt <= 4'h0;
                state   <= ST_MACK;
              end else begin
                sda_oe <= ~shreg[7];
                shreg  <= {shreg[6:0], 1'b0};
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              ack_seen <= ~sda_f;
              bit_cnt  <= `IMS_BITS_BYTE;
            end else if (scl_fall && bit_cnt == `IMS_BITS_BYTE) begin
              bit_cnt <= 4'h0;
              if (ack_seen) begin
                shreg  <= {rd_buf[6:0], 1'b0};
                sda_oe <= ~rd_buf[7];
                state  <= ST_TX;
              end else begin
                state    <= ST_IDLE;
                selected <= 1'b0;
              end
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************
  // Two-entry write buffer
  // ****************************************
  // Head entry drives the outputs; second entry absorbs one stall
  // No clock stretching, so a full buffer can only refuse a byte
  reg [AW-1:0] hold_addr;
  reg [7:0]    hold_data;
  wire         pop = wr_valid & wr_ready;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_valid  <= 1'b0;
      wr_addr   <= `IMS_ADDR_RESET;
      wr_data   <= 8'h00;
      hold_v    <= 1'b0;
      hold_addr <= `IMS_ADDR_RESET;
      hold_data <= 8'h00;
    end else if (push && (!wr_valid || (pop && !hold_v))) begin
      wr_valid <= 1'b1;
      wr_addr  <= push_addr;
      wr_data  <= push_data;
    end else if (push && pop) begin
      wr_addr   <= hold_addr;
      wr_data   <= hold_data;
      hold_addr <= push_addr;
      hold_data <= push_data;
    end else if (push) begin
      hold_v    <= 1'b1;
      hold_addr <= push_addr;
      hold_data <= push_data;
    end else if (pop && hold_v) begin
      wr_addr <= hold_addr;
      wr_data <= hold_data;
      hold_v  <= 1'b0;
    end else if (pop) begin
      wr_valid <= 1'b0;
    end
  end

endmodule // ims_top

// ### testbench/ims_master.sv
// Two-wire bus master model: makes SCL, pulls SDA low open drain.
// Assumes the bench resolves SDA from all pull-downs with a pull-up.
`timescale 1ns/1ns
module ims_master (
  input  wire clk,
  input  wire sda_w,
  output reg  scl,
  output reg  sda_low
);
  // ****
  // Bit timing, 80 ns per SCL period
  // ****
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task w(input integer n);
    repeat (n) @(negedge clk);
  endtask
  // Sample late in the high phase, the slave launches late in the low phase
  // Five-clock low phase: the slave's answer settles before SCL rises
  task bitx(input logic b, output logic r);
    w(2);
    sda_low = ~b;
    w(3);
    scl = 1'b1;
    w(3);
    r = sda_w;
    scl = 1'b0;
  endtask
  // Longer low phase so a slave ack is released before SCL rises
  task start;
    w(2);
    sda_low = 1'b0;
    w(4);
    scl = 1'b1;
    w(4);
    sda_low = 1'b1;
    w(4);
    scl = 1'b0;
  endtask
  task stop;
    w(2);
    sda_low = 1'b1;
    w(2);
    scl = 1'b1;
    w(4);
    sda_low = 1'b0;
    // Long enough for the slave's filtered view to see the stop
    w(8);
  endtask
  task wbyte(input logic [7:0] b, output logic ack);
    integer i;
    logic   r;
    for (i = 7; i >= 0; i--) bitx(b[i], r);
    bitx(1'b1, r);
    ack = ~r;
  endtask
  task rbyte(input logic ack, output logic [7:0] b);
    integer i;
    logic   r;
    for (i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      b[i] = r;
    end
    bitx(~ack, r);
  endtask
endmodule // ims_master

// ### testbench/ims_top_assertions.sv
// Checker for the slave front end, watching top-level ports only.
// Assumes one clock domain and the active-low rstn.
`timescale 1ns/1ns
module ims_top_assertions #(
  parameter AW = 15
) (
  input wire          clk_sys,
  input wire          rstn,
  input wire          scl_in,
  input wire          sda_in,
  input wire          sda_out,
  input wire          sda_oe,
  input wire          write_protect,
  input wire          wr_valid,
  input wire          wr_ready,
  input wire [AW-1:0] wr_addr,
  input wire [7:0]    wr_data,
  input wire          rd_req,
  input wire          hs_mode,
  input wire          selected
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  reg       scl_q;
  reg [3:0] since_fall;
  // Saturating count since the last SCL fall at the pin
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      scl_q <= 1'b1;
      since_fall <= 4'hf;
    end else begin
      scl_q <= scl_in;
      if (scl_q && !scl_in) since_fall <= 4'h0;
      else if (since_fall != 4'hf) since_fall <= since_fall + 4'h1;
    end
  end
  // ****
  // Conditions and properties
  // ****
  sequence s_start;
    scl_in && sda_in ##1 scl_in && !sda_in;
  endsequence
  sequence s_stop;
    scl_in && !sda_in ##1 scl_in && sda_in;
  endsequence
  sequence s_head_kept;
    wr_valid && $stable(wr_addr) && $stable(wr_data);
  endsequence
  a_open_drain: assert property (sda_out == 1'b0)
    else $error("sda_out not low");
  a_oe_after_fall: assert property ($changed(sda_oe) |-> since_fall <= 4'h9)
    else $error("sda_oe moved far from a SCL fall");
  a_stop_ends_hs: assert property (s_stop |-> ##[1:10] !hs_mode)
    else $error("hs_mode kept after stop");
  a_start_deselect: assert property (s_start |-> ##[1:10] !selected)
    else $error("selected kept after start");
  a_hs_no_ack: assert property ($rose(hs_mode) |-> !sda_oe)
    else $error("master code acknowledged");
  a_rdreq_pulse: assert property (rd_req |=> !rd_req)
    else $error("rd_req longer than one cycle");
  a_wr_hold: assert property (wr_valid && !wr_ready |=> s_head_kept)
    else $error("write head changed before taken");
  a_wp_no_push: assert property (write_protect [*8] |-> !$rose(wr_valid))
    else $error("write pushed while protected");
endmodule // ims_top_assertions
bind ims_top ims_top_assertions #(.AW(AW)) ims_top_assertions_inst (
  .clk_sys(clk_sys), .rstn(rstn), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .write_protect(write_protect), .wr_valid(wr_valid),
  .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data), .rd_req(rd_req),
  .hs_mode(hs_mode), .selected(selected));

// ### testbench/ims_top_tb.sv
// Self-checking bench: bus master model, memory model, write stalls.
// Assumes ims_top, ims_master and the bound checker are compiled first.
`timescale 1ns/1ns
module ims_top_tb;
  logic        clk_sys = 0, rstn = 0, wp = 0, wr_ready = 1, rd_valid = 0, hold = 0;
  logic [7:0]  rd_data = 0, r, d [0:2];
  logic [2:0]  sel = 0;
  logic [14:0] a;
  logic        ack;
  wire         scl, m_low, sda_out, sda_oe, wr_valid, rd_req, hs_mode, selected;
  wire [14:0]  wr_addr, rd_addr;
  wire [7:0]   wr_data;
  wire         sda_w = ~(m_low | sda_oe);
  integer      seed = 32'h4b7a8021, failures = 0, n_checks = 0, i;
  logic [7:0]  mem [0:32767];
  logic [22:0] exq [$];
  always #5 clk_sys = ~clk_sys;
  ims_master ims_master_inst (.clk(clk_sys), .sda_w(sda_w), .scl(scl), .sda_low(m_low));
  ims_top ims_top_inst (.clk_sys(clk_sys), .rstn(rstn), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe), .device_select_pins(sel), .write_protect(wp),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
    .hs_mode(hs_mode), .selected(selected));
  // ****
  // Memory model, random write stalls
  // ****
  always @(negedge clk_sys) begin
    rd_valid <= rd_req;
    rd_data <= mem[rd_addr];
    wr_ready <= hold ? 1'b0 : ($random(seed) % 4 != 0);
  end
  always @(posedge clk_sys) begin
    if (wr_valid && wr_ready) begin
      mem[wr_addr] <= wr_data;
      cmp("wr", exq.pop_front(), {wr_addr, wr_data});
    end
  end
  task cmp(input string nm, input logic [23:0] e, input logic [23:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task wb(input logic [7:0] b, input logic e);
    ims_master_inst.wbyte(b, ack);
    cmp("ack", e, ack);
  endtask
  // High address bit set on purpose, it must be ignored
  task put(input logic [14:0] ad);
    ims_master_inst.start();
    wb({4'ha, sel, 1'b0}, 1'b1);
    wb({1'b1, ad[14:8]}, 1'b1);
    wb(ad[7:0], 1'b1);
  endtask
  task give_verdict;
    if (failures == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task drain;
    for (i = 0; i < 400 && exq.size() != 0; i++) @(negedge clk_sys);
    cmp("drain", 0, 24'(exq.size()));
  endtask
  initial begin
    #300000;
    failures++;
    give_verdict();
  end
  // ****
  // Scenarios
  // ****
  initial begin
    sel = 3'($random(seed));
    repeat (5) @(negedge clk_sys);
    rstn = 1;
    repeat (10) @(negedge clk_sys);
    cmp("rst", 0, {sda_oe, selected, hs_mode, wr_valid, rd_addr});
    a = 15'h7ffe;
    put(a);
    for (i = 0; i < 3; i++) begin
      d[i] = 8'($random(seed));
      exq.push_back({a, d[i]});
      wb(d[i], 1'b1);
      a = a + 15'h1;
    end
    ims_master_inst.stop();
    drain();
    cmp("latch", 15'h0001, rd_addr);
    put(15'h7ffe);
    ims_master_inst.start();
    wb({4'ha, sel, 1'b1}, 1'b1);
    for (i = 0; i < 3; i++) begin
      ims_master_inst.rbyte(i < 2, r);
      cmp("rd", d[i], r);
    end
    repeat (6) @(negedge clk_sys);
    cmp("nack", 0, selected);
    ims_master_inst.stop();
    cmp("latch", 15'h0001, rd_addr);
    ims_master_inst.start();
    wb({4'ha, ~sel, 1'b0}, 1'b0);
    ims_master_inst.start();
    wb({4'hb, sel, 1'b1}, 1'b0);
    ims_master_inst.stop();
    cmp("sel", 0, selected);
    ims_master_inst.start();
    wb({5'h01, 3'($random(seed))}, 1'b0);
    cmp("hs", 1, hs_mode);
    put(15'h0040);
    ims_master_inst.stop();
    cmp("hs", 0, hs_mode);
    wp = 1;
    put(15'h0100);
    wb(8'h5a, 1'b0);
    ims_master_inst.stop();
    cmp("latch", 15'h0100, rd_addr);
    wp = 0;
    hold = 1;
    put(15'h0200);
    for (i = 0; i < 3; i++) begin
      d[i] = 8'($random(seed));
      if (i < 2) exq.push_back({15'h0200 + 15'(i), d[i]});
      wb(d[i], i < 2);
    end
    ims_master_inst.stop();
    hold = 0;
    drain();
    cmp("latch", 15'h0202, rd_addr);
    give_verdict();
  end
endmodule // ims_top_tb
